// ### design/sapr_top.sv
// Conversion sequencer and three-state parallel readout of the converter.
module sapr_top
(
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Host strobes, all asynchronous pins
  input  wire logic                           conversion_start_n,
  input  wire logic                           chip_select_n,
  input  wire logic                           read_n,
  input  wire logic                           half_select,
  input  wire logic                           conv_clock,
  // Quantised input seen by the sample switch, two's complement
  input  wire logic [sapr_pkg::SAPR_WIDTH-1:0] sample_in,
  // Status
  output logic                                busy,
  output logic                                hold,
  // Output bus pins
  output logic [sapr_pkg::SAPR_WIDTH-1:0]     output_bus,
  output logic                                output_bus_oe
);
  import sapr_pkg::*;

  sapr_sar_if sar ();

  sapr_sar_engine u_engine
  (
    .clk (clk),
    .rst (rst),
    .sar (sar)
  );

  // Synchronisers; the start strobe and conversion clock run through three stages, the other pins through two.
  logic strb_s1;
  logic strb_s2;
  logic strb_s3;
  logic cs_s1;
  logic cs_s2;
  logic rd_s1;
  logic rd_s2;
  logic byte_s1;
  logic byte_s2;
  logic cclk_s1;
  logic cclk_s2;
  logic cclk_s3;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strb_s1 <= 1'b1;
      strb_s2 <= 1'b1;
      strb_s3 <= 1'b1;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      rd_s1   <= 1'b1;
      rd_s2   <= 1'b1;
      byte_s1 <= 1'b0;
      byte_s2 <= 1'b0;
      cclk_s1 <= 1'b0;
      cclk_s2 <= 1'b0;
      cclk_s3 <= 1'b0;
    end
    else
    begin
      strb_s1 <= conversion_start_n;
      strb_s2 <= strb_s1;
      strb_s3 <= strb_s2;
      cs_s1   <= chip_select_n;
      cs_s2   <= cs_s1;
      rd_s1   <= read_n;
      rd_s2   <= rd_s1;
      byte_s1 <= half_select;
      byte_s2 <= byte_s1;
      cclk_s1 <= conv_clock;
      cclk_s2 <= cclk_s1;
      cclk_s3 <= cclk_s2;
    end
  end

  logic strb_fall;
  logic cclk_rise;
  logic start;
  logic last_edge;

  // Only a falling edge counts, so a strobe parked low starts nothing.
  assign strb_fall = strb_s3 & ~strb_s2;
  assign cclk_rise = cclk_s2 & ~cclk_s3;

  // Sequencer state.
  sapr_state_t st_q;
  sapr_state_t st_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [15:0] held_q;
  logic [15:0] held_d;
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic        busy_q;
  logic        busy_d;
  logic        hold_q;
  logic        hold_d;
  logic        step;

  assign start     = (st_q == SAPR_ST_IDLE) && strb_fall && !cs_s2;
  assign last_edge = (st_q == SAPR_ST_CONV) && cclk_rise && (cnt_q == SAPR_LAST_EDGE);

  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    held_d   = held_q;
    result_d = result_q;
    busy_d   = busy_q;
    hold_d   = hold_q;
    step     = 1'b0;
    case (st_q)
      SAPR_ST_IDLE:
      begin
        if (start)
        begin
          held_d = sample_in;
          hold_d = 1'b1;
          busy_d = 1'b1;
          cnt_d  = SAPR_CNT_RESET;
          st_d   = SAPR_ST_CONV;
        end
      end
      SAPR_ST_CONV:
      begin
        // Strobe edges are not looked at here.
        if (cclk_rise)
        begin
          if (cnt_q == SAPR_LAST_EDGE)
          begin
            result_d = sar.result;
            busy_d   = 1'b0;
            hold_d   = 1'b0;
            st_d     = SAPR_ST_IDLE;
          end
          else
          begin
            step  = 1'b1;
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      default:
      begin
        st_d = SAPR_ST_IDLE;
      end
    endcase
  end

  assign sar.start      = start;
  assign sar.step       = step;
  assign sar.load_value = sample_in;

  // Readout; the byte choice is re-evaluated every cycle even with read held low.
  logic        oe_d;
  logic [15:0] bus_d;

  always_comb
  begin
    oe_d  = !cs_s2 && !rd_s2;
    bus_d = SAPR_DATA_RESET;
    if (oe_d)
    begin
      if (byte_s2)
      begin
        bus_d = {8'h00, result_q[SAPR_WIDTH-1:SAPR_BYTE_HI_LSB]};
      end
      else
      begin
        bus_d = result_q;
      end
    end
  end

  logic [15:0] bus_q;
  logic        oe_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q     <= SAPR_ST_IDLE;
      cnt_q    <= SAPR_CNT_RESET;
      held_q   <= SAPR_DATA_RESET;
      result_q <= SAPR_DATA_RESET;
      busy_q   <= 1'b0;
      hold_q   <= 1'b0;
      bus_q    <= SAPR_DATA_RESET;
      oe_q     <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      held_q   <= held_d;
      result_q <= result_d;
      busy_q   <= busy_d;
      hold_q   <= hold_d;
      bus_q    <= bus_d;
      oe_q     <= oe_d;
    end
  end

  assign busy          = busy_q;
  assign hold          = hold_q;
  assign output_bus    = bus_q;
  assign output_bus_oe = oe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_on_start: assert property (start |=> busy_q && hold_q)
    else $error("busy or hold not raised after start");
  a_busy_prompt: assert property ($fell(strb_s2) && !cs_s2 && !busy_q |-> ##[1:2] busy_q)
    else $error("busy late after strobe fall");
  a_hold_tracks: assert property (hold_q == busy_q)
    else $error("hold and busy disagree");
  a_busy_cause: assert property ($changed(busy_q) |-> $past(start) || $past(last_edge))
    else $error("busy changed without cause");
  a_strobe_ignored: assert property (busy_q && strb_fall && !last_edge |=> busy_q)
    else $error("strobe during conversion disturbed it");
  a_count_range: assert property (busy_q |-> cnt_q <= SAPR_LAST_EDGE)
    else $error("edge count overran");
  a_result_latch: assert property (last_edge |=> !busy_q && result_q == $past(held_q))
    else $error("result not latched on 17th edge");
  a_bus_release: assert property ((cs_s2 || rd_s2) |=> !output_bus_oe)
    else $error("bus driven without select and read");
  a_byte_select: assert property
    (oe_d && byte_s2 |=> bus_q == {8'h00, $past(result_q[15:8])})
    else $error("upper byte not on lower lines");
  a_reset_idle: assert property ($past(rst) |-> !busy_q && !oe_q && st_q == SAPR_ST_IDLE)
    else $error("not idle after reset");

  c_conversion: cover property (start ##[1:500] last_edge);
  c_retrigger: cover property (busy_q && strb_fall);
  c_byte_read: cover property (oe_q && !byte_s2 ##[1:20] oe_q && byte_s2);

endmodule

// ### design/sapr_pkg.sv
// Shared constants for the converter control and parallel readout block.
// Functional notes
// - Falling start strobe moves the input from sampling to hold.
// - Conversion begins at first conversion clock rise after strobe; 16 rises convert.
// - Busy rises within 25ns of the strobe falling and stays high throughout.
// - The 17th conversion clock rise latches the result, then busy falls.
// - Busy starts low; reads and sampling never change it.
// - Further strobes are ignored until conversion ends; a held-low strobe restarts nothing.
// - After a conversion the input samples again; host allows 400ns acquisition.
// - Output bus is released unless chip select and read strobe are both low.
// - Half-select low drives all 16 bits; high puts upper byte on lower lines.
// - Results are 16-bit two's complement, 7fff down to 8000.
// - Half-select acts on the bus at any time, even with read strobe held low; here it acts only while chip select and read strobe are both low.
package sapr_pkg;

  localparam int          SAPR_CLK_PERIOD_NS = 5;
  localparam int          SAPR_WIDTH         = 16;
  localparam int          SAPR_CONV_EDGES    = 16;
  localparam logic [4:0]  SAPR_LAST_EDGE     = 5'h10;
  localparam logic [4:0]  SAPR_CNT_RESET     = 5'h00;
  localparam logic [15:0] SAPR_MSB_MASK      = 16'h8000;
  localparam logic [15:0] SAPR_DATA_RESET    = 16'h0000;
  localparam int          SAPR_BYTE_HI_LSB   = 8;

  // Longest delay from strobe fall to busy high, and its cycle budget.
  localparam int SAPR_BUSY_RISE_NS  = 25;
  localparam int SAPR_BUSY_RISE_CYC = SAPR_BUSY_RISE_NS / SAPR_CLK_PERIOD_NS;

  typedef enum logic [0:0]
  {
    SAPR_ST_IDLE = 1'b0,
    SAPR_ST_CONV = 1'b1
  } sapr_state_t;

  // Two's complement and offset binary differ only in the sign bit.
  function automatic logic [15:0] sapr_flip_sign(input logic [15:0] v);
    sapr_flip_sign = v ^ SAPR_MSB_MASK;
  endfunction

endpackage

// ### design/sapr_sar_if.sv
// Link between the sequencer and the bit-trial engine.
interface sapr_sar_if;
  import sapr_pkg::*;

  logic        start;
  logic        step;
  logic [15:0] load_value;
  logic [15:0] result;

  modport ctrl
  (
    output start,
    output step,
    output load_value,
    input  result
  );

  modport eng
  (
    input  start,
    input  step,
    input  load_value,
    output result
  );
endinterface

// ### design/sapr_sar_engine.sv
// Successive approximation bit-trial engine, one bit per step, MSB first.
module sapr_sar_engine
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer link
  sapr_sar_if.eng  sar
);
  import sapr_pkg::*;

  logic [15:0] target_q;
  logic [15:0] target_d;
  logic [15:0] trial_q;
  logic [15:0] trial_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] cand;

  always_comb
  begin
    target_d = target_q;
    trial_d  = trial_q;
    mask_d   = mask_q;
    cand     = trial_q | mask_q;
    if (sar.start)
    begin
      // Comparing in offset binary keeps the trial an unsigned compare.
      target_d = sapr_flip_sign(sar.load_value);
      trial_d  = SAPR_DATA_RESET;
      mask_d   = SAPR_MSB_MASK;
    end
    else if (sar.step)
    begin
      if (cand <= target_q)
      begin
        trial_d = cand;
      end
      mask_d = mask_q >> 1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      target_q <= SAPR_DATA_RESET;
      trial_q  <= SAPR_DATA_RESET;
      mask_q   <= SAPR_DATA_RESET;
    end
    else
    begin
      target_q <= target_d;
      trial_q  <= trial_d;
      mask_q   <= mask_d;
    end
  end

  assign sar.result = sapr_flip_sign(trial_q);

endmodule

// ### verification/sapr_host.sv
// Host model that drives the converter's strobes, conversion clock and input value.
module sapr_host
(
  // Clock
  input  wire logic   clk,
  // Pins toward the converter
  output logic        conversion_start_n,
  output logic        chip_select_n,
  output logic        read_n,
  output logic        half_select,
  output logic        conv_clock,
  output logic [15:0] sample_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] ph_q;

  initial
  begin
    conversion_start_n = 1'b1;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    half_select = 1'b0;
    conv_clock = 1'b0;
    ph_q = 4'h0;
    sample_in = 16'h0000;
  end

  // Ten system cycles a phase keeps the conversion clock at its fastest legal rate.
  always @(posedge clk)
  begin
    ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
    if (ph_q == 4'h9)
      conv_clock <= ~conv_clock;
  end

  // The strobe falls as the conversion clock falls, 50ns ahead of the next rise.
  task automatic start(input logic [15:0] v, input logic cs_n);
    chip_select_n <= cs_n;
    sample_in <= v;
    // A 125ns pause keeps the strobe fall clear of a read that has just ended.
    repeat (25) @(posedge clk);
    do
      @(posedge clk);
    while (!(ph_q == 4'h9 && conv_clock));
    conversion_start_n <= 1'b0;
  endtask

  // Every caller keeps a level for at least four cycles, so both widths exceed 20ns.
  task automatic strobe(input logic lvl);
    conversion_start_n <= lvl;
  endtask

  // Waits 40ns with both strobes low before the bus is judged.
  task automatic rd(input logic hs);
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
    half_select <= hs;
    repeat (8) @(posedge clk);
  endtask

  task automatic rd_end();
    read_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ### verification/sapr_top_bench.sv
// Self-checking bench for the conversion sequencer and parallel readout.
module sapr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sapr_pkg::*;

  logic             clk;
  logic             rst;
  wire logic        conversion_start_n;
  wire logic        chip_select_n;
  wire logic        read_n;
  wire logic        half_select;
  wire logic        conv_clock;
  wire logic [15:0] sample_in;
  wire logic        busy;
  wire logic        hold;
  wire logic [15:0] output_bus;
  wire logic        output_bus_oe;
  logic [15:0]      last;
  int               n_fail;
  int               tests_run;

  sapr_host sapr_host_i (.clk(clk), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .half_select(half_select),
    .conv_clock(conv_clock), .sample_in(sample_in));

  sapr_top sapr_top_i (.clk(clk), .rst(rst), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .half_select(half_select),
    .conv_clock(conv_clock), .sample_in(sample_in), .busy(busy), .hold(hold),
    .output_bus(output_bus), .output_bus_oe(output_bus_oe));

  always #2.5 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check_idle(input string name);
    chk({name, " busy"}, busy, 1'b0);
    chk({name, " hold"}, hold, 1'b0);
    chk({name, " oe"}, output_bus_oe, 1'b0);
  endtask

  // Mode 1 adds a stray strobe and a read mid-run; mode 2 leaves the strobe low.
  task automatic conv(input logic [15:0] v, input int mode);
    int  n;
    int  rises;
    logic cc;
    n = 0;
    rises = 0;
    sapr_host_i.start(v, 1'b0);
    #1;
    while (busy !== 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    chk("busy delay", n <= SAPR_BUSY_RISE_CYC, 1'b1);
    chk("hold at start", hold, 1'b1);
    tick();
    if (mode != 2)
      sapr_host_i.strobe(1'b1);
    cc = conv_clock;
    while (busy === 1'b1 && n < 600)
    begin
      tick();
      n++;
      if (conv_clock && !cc)
        rises++;
      cc = conv_clock;
      if (mode == 1 && n == 20)
        sapr_host_i.strobe(1'b0);
      if (mode == 1 && n == 26)
        sapr_host_i.strobe(1'b1);
      if (mode == 1 && n == 60)
      begin
        sapr_host_i.rd(1'b0);
        #1;
        chk("old word", output_bus, last);
        chk("busy in read", busy, 1'b1);
        sapr_host_i.rd_end();
        #1;
      end
    end
    chk("rises", rises, 16'h0011);
    chk("hold end", hold, 1'b0);
    repeat (80) tick();
    chk("no restart", busy, 1'b0);
    if (mode == 2)
      sapr_host_i.strobe(1'b1);
    sapr_host_i.rd(1'b0);
    #1;
    chk("oe", output_bus_oe, 1'b1);
    chk("word", output_bus, v);
    sapr_host_i.rd_end();
    #1;
    chk("released bus", output_bus, 16'h0000);
    check_idle("after read");
    last = v;
  endtask

  // The read strobe stays low while the byte select moves.
  task automatic bytes();
    sapr_host_i.rd(1'b0);
    #1;
    chk("low pass", output_bus, last);
    sapr_host_i.rd(1'b1);
    #1;
    chk("high pass", output_bus, {8'h00, last[15:8]});
    sapr_host_i.rd(1'b0);
    #1;
    chk("back to word", output_bus, last);
    sapr_host_i.rd_end();
  endtask

  task automatic refuse();
    sapr_host_i.start(16'h1234, 1'b1);
    repeat (5) tick();
    sapr_host_i.strobe(1'b1);
    repeat (10) tick();
    check_idle("deselected");
  endtask

  task automatic mid_reset();
    sapr_host_i.start(16'h0001, 1'b0);
    repeat (30) tick();
    rst <= 1'b1;
    tick();
    check_idle("mid reset");
    rst <= 1'b0;
    sapr_host_i.strobe(1'b1);
    repeat (20) tick();
    check_idle("after reset");
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    n_fail = 0;
    tests_run = 0;
    last = 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick();
    check_idle("reset");
    conv(16'h7fff, 0);
    conv(16'h0000, 1);
    conv(16'hffff, 2);
    conv(16'h8000, 0);
    bytes();
    refuse();
    mid_reset();
    conv(16'h5a3c, 0);
    wrap_up();
  end

  // Whole run takes about 13us; a hang past 60us is cut short.
  initial
  begin
    #60000;
    n_fail++;
    wrap_up();
  end
endmodule
